// ===== rtl/spisf_top.sv
// spisf_top.sv: byte-wide spi port with status flags, wishbone registers
// and pin direction control.
// assumes classic wishbone on clk_i; pins are asynchronous to clk_i.
//
// Behaviour
// - reading receive buffer clears overrun flag
// - unread buffer at next byte end sets overrun
// - overrun with overwrite on replaces buffered byte
// - overrun with overwrite off drops new byte
// - new byte sets receive flag, may interrupt
// - mode zero halts on unread receive buffer
// - receive-full flag while buffer holds byte
// - dry transmit buffer sets underflow; zero-write clears
// - transmit write clears transmit-empty flag
// - empty transmit buffer sets flag, may interrupt
// - mode one halts without new transmit byte
// - zero-write clears transmit-empty flag
// - transmit-full flag while byte pending; zero-write clears
// - master-in input as master, output as slave
// - master-out output as master, input as slave
// - eight-bit units, msb first by default
`timescale 1ns/1ns
`include "spisf_params.svh"
`default_nettype none

module spisf_top
    import spisf_pkg::*;
#(
    parameter int HALF_CYC = `SPISF_HALF_CYC
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // spi pins
    input wire spisf_pin_in_t pin_i,
    output spisf_pin_out_t pin_o,
    // interrupt
    output logic irq_o
);

    // ***************************************
    // address decode
    // ***************************************
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction

    logic ack_reg;
    logic [31:0] dat_reg;
    logic req;
    logic acc;
    logic wr_ok;
    logic rd_rx;
    logic wr_tx;
    logic wr_st;
    logic wr_ctrl;
    logic wr_evt;
    logic wr_mask;
    logic [7:0] wd;

    assign req = wb_cyc_i & wb_stb_i;
    // side effects happen at the edge where the master sees ack
    assign acc = req & ack_reg;
    assign wr_ok = acc & wb_we_i & wb_sel_i[0];
    assign wd = wb_dat_i[7:0];
    assign rd_rx = acc & ~wb_we_i & hit(wb_adr_i, `SPISF_ADR_RXBUF);
    assign wr_tx = wr_ok & hit(wb_adr_i, `SPISF_ADR_TXBUF);
    assign wr_st = wr_ok & hit(wb_adr_i, `SPISF_ADR_STAT);
    assign wr_ctrl = wr_ok & hit(wb_adr_i, `SPISF_ADR_CTRL);
    assign wr_evt = wr_ok & hit(wb_adr_i, `SPISF_ADR_EVT);
    assign wr_mask = wr_ok & hit(wb_adr_i, `SPISF_ADR_MASK);

    // ***************************************
    // pin synchronisers
    // ***************************************
    logic [3:0] pin_s;
    logic sclk_s;
    logic ss_n_s;
    logic mosi_s;
    logic miso_s;
    logic sclk_d_reg;
    logic ss_n_d_reg;

    spisf_sync #(
        .W(4)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({pin_i.sclk, ~pin_i.ss_n, pin_i.mosi, pin_i.miso}),
        .q_o(pin_s)
    );

    // select travels inverted so its reset level is idle: no false start
    assign {sclk_s, ss_n_s, mosi_s, miso_s} = pin_s ^ 4'h4;

    // edge detection reads the second stage only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_d_reg <= 1'b0;
            ss_n_d_reg <= 1'b1;
        end else if (ce_i) begin
            sclk_d_reg <= sclk_s;
            ss_n_d_reg <= ss_n_s;
        end
    end

    // ***************************************
    // control register
    // ***************************************
    logic [7:0] ctrl_reg;
    logic transfer_irq_mode;
    logic ovwr;
    logic master;
    logic lsbf;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `SPISF_CTRL_RST;
        end else if (ce_i && wr_ctrl) begin
            ctrl_reg <= {4'h0, wd[3:0]};
        end
    end

    // transfer_irq_mode must stay one for proper operation
    assign transfer_irq_mode = ctrl_reg[`SPISF_C_TRANSFER_IRQ_MODE];
    assign ovwr = ctrl_reg[`SPISF_C_OVWR];
    assign master = ctrl_reg[`SPISF_C_MASTER];
    assign lsbf = ctrl_reg[`SPISF_C_LSBF];

    // ***************************************
    // shift engine
    // ***************************************
    spisf_state_t state_reg;
    spisf_state_t state_next;
    logic [7:0] div_reg;
    logic sclk_reg;
    logic halt_reg;
    logic [2:0] bit_reg;
    logic [7:0] sh_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_sh_next;
    logic [7:0] txbuf_reg;
    logic [7:0] rxbuf_reg;
    logic rxof_reg;
    logic rxirq_reg;
    logic rxbf_reg;
    logic txuf_reg;
    logic txirq_reg;
    logic txbf_reg;
    logic m_on;
    logic tick;
    logic m_rise;
    logic m_fall;
    logic s_rise;
    logic s_fall;
    logic s_start;
    logic s_active;
    logic sample_ev;
    logic shift_ev;
    logic din;
    logic byte_end;
    logic stop;
    logic m_start;
    logic load_tx;
    logic load_zero;
    logic underflow;
    logic rx_overrun;
    logic rx_store;
    logic busy;

    assign m_on = master & (state_reg != SPISF_IDLE);
    assign tick = m_on & (div_reg == 8'(HALF_CYC - 1));
    assign m_rise = tick & ~sclk_reg;
    assign m_fall = tick & sclk_reg;
    assign s_rise = sclk_s & ~sclk_d_reg;
    assign s_fall = ~sclk_s & sclk_d_reg;
    assign s_start = ~master & ~ss_n_s & ss_n_d_reg;
    assign s_active = ~master & ~ss_n_s & ~halt_reg & ~s_start;
    assign din = master ? miso_s : mosi_s;
    assign sample_ev = master ? (m_rise & (state_reg == SPISF_RUN)) : (s_rise & s_active);
    assign shift_ev = master ? (m_fall & (state_reg == SPISF_RUN)) : (s_fall & s_active);
    // eight bits per unit, msb first unless lsb-first is chosen
    assign rx_sh_next = lsbf ? {din, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], din};
    assign byte_end = sample_ev & (bit_reg == 3'h7);
    // mode one halts on empty transmit buffer
    // mode zero also halts on an unread receive buffer
    assign stop = transfer_irq_mode ? ~txbf_reg : (rxbf_reg | ~txbf_reg);
    assign m_start = master & (state_reg == SPISF_IDLE) & txbf_reg;
    assign load_tx = m_start | (s_start & txbf_reg) | (byte_end & ~stop);
    assign load_zero = s_start & ~txbf_reg;
    // buffer ran dry when a byte was wanted
    assign underflow = load_zero | (byte_end & ~txbf_reg);
    // unread buffer at byte end is an overrun
    assign rx_overrun = byte_end & rxbf_reg;
    // overwrite replaces, otherwise the new byte is dropped
    assign rx_store = byte_end & (~rxbf_reg | ovwr);
    assign busy = master ? (state_reg != SPISF_IDLE) : (~ss_n_s & ~halt_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SPISF_IDLE: begin
                if (m_start) begin
                    state_next = SPISF_RUN;
                end
            end
            SPISF_RUN: begin
                if (~master) begin
                    state_next = SPISF_IDLE;
                end else if (byte_end && stop) begin
                    state_next = SPISF_DRAIN;
                end
            end
            SPISF_DRAIN: begin
                if (m_fall || ~master) begin
                    state_next = SPISF_IDLE;
                end
            end
            default: begin
                state_next = SPISF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SPISF_IDLE;
            div_reg <= 8'h00;
            sclk_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            div_reg <= (tick || !m_on) ? 8'h00 : div_reg + 8'h01;
            sclk_reg <= m_on ? (sclk_reg ^ tick) : 1'b0;
        end
    end

    // a halted slave ignores the clock until it is deselected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_reg <= 1'b0;
        end else if (ce_i) begin
            if (master || ss_n_s) begin
                halt_reg <= 1'b0;
            end else if (byte_end && stop) begin
                halt_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
        end else if (ce_i) begin
            if (m_start || s_start) begin
                bit_reg <= 3'h0;
            end else if (sample_ev) begin
                bit_reg <= bit_reg + 3'h1;
                rx_sh_reg <= rx_sh_next;
            end
        end
    end

    // the first falling edge of a byte comes after bit 0 is sampled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_reg <= 8'h00;
        end else if (ce_i) begin
            if (load_tx) begin
                sh_reg <= txbuf_reg;
            end else if (load_zero) begin
                sh_reg <= 8'h00;
            end else if (shift_ev && bit_reg != 3'h0) begin
                sh_reg <= lsbf ? {1'b0, sh_reg[7:1]} : {sh_reg[6:0], 1'b0};
            end
        end
    end

    // ***************************************
    // data buffers
    // ***************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txbuf_reg <= 8'h00;
            rxbuf_reg <= 8'h00;
        end else if (ce_i) begin
            if (wr_tx) begin
                txbuf_reg <= wd;
            end
            if (rx_store) begin
                rxbuf_reg <= rx_sh_next;
            end
        end
    end

    // ***************************************
    // status flags (set wins over clear, except transmit-empty, where a buffer write wins)
    // ***************************************
    logic rxof_next;
    logic rxirq_next;
    logic rxbf_next;
    logic txuf_next;
    logic txirq_next;
    logic txbf_next;

    assign rxof_next = rx_overrun | (rxof_reg & ~rd_rx);
    assign rxirq_next = rx_store | (rxirq_reg & ~rd_rx);
    assign rxbf_next = rx_store | (rxbf_reg & ~rd_rx);
    assign txuf_next = underflow | (txuf_reg & ~(wr_st & ~wd[`SPISF_B_TXUF]));
    // a buffer write in the same cycle leaves it full, so the write wins
    assign txirq_next = ~wr_tx & (load_tx | (txirq_reg & ~(wr_st & ~wd[`SPISF_B_TXIRQ])));
    assign txbf_next = wr_tx | (txbf_reg & ~load_tx & ~(wr_st & ~wd[`SPISF_B_TXBF]));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxof_reg <= 1'b0;
            rxirq_reg <= 1'b0;
            rxbf_reg <= 1'b0;
            txuf_reg <= 1'b0;
            txirq_reg <= 1'b0;
            txbf_reg <= 1'b0;
        end else if (ce_i) begin
            rxof_reg <= rxof_next;
            rxirq_reg <= rxirq_next;
            rxbf_reg <= rxbf_next;
            txuf_reg <= txuf_next;
            txirq_reg <= txirq_next;
            txbf_reg <= txbf_next;
        end
    end

    // ***************************************
    // interrupt events
    // ***************************************
    logic [3:0] evt_reg;
    logic [3:0] evt_set;
    logic [3:0] evt_clr;
    logic [3:0] mask_reg;

    assign evt_set = {underflow, rx_overrun, rx_store, load_tx};
    assign evt_clr = wr_evt ? wd[3:0] : 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_reg <= 4'h0;
            mask_reg <= 4'h0;
        end else if (ce_i) begin
            evt_reg <= evt_set | (evt_reg & ~evt_clr);
            if (wr_mask) begin
                mask_reg <= wd[3:0];
            end
        end
    end

    assign irq_o = |(evt_reg & mask_reg);

    // ***************************************
    // wishbone read path
    // ***************************************
    logic [7:0] stat_word;
    logic [7:0] rd_word;

    assign stat_word = {busy, 1'b0, rxof_reg, rxirq_reg, rxbf_reg, txuf_reg, txirq_reg, txbf_reg};
    // unmapped offsets still ack, reading zero
    assign rd_word = hit(wb_adr_i, `SPISF_ADR_STAT) ? stat_word :
                     hit(wb_adr_i, `SPISF_ADR_RXBUF) ? rxbuf_reg :
                     hit(wb_adr_i, `SPISF_ADR_TXBUF) ? txbuf_reg :
                     hit(wb_adr_i, `SPISF_ADR_CTRL) ? ctrl_reg :
                     hit(wb_adr_i, `SPISF_ADR_EVT) ? {4'h0, evt_reg} :
                     hit(wb_adr_i, `SPISF_ADR_MASK) ? {4'h0, mask_reg} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= req & ~ack_reg;
            if (req && !ack_reg) begin
                dat_reg <= {24'h00_0000, rd_word};
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ***************************************
    // pin drives
    // ***************************************
    always_comb begin
        pin_o.sclk = sclk_reg;
        pin_o.sclk_oe = master;
        pin_o.ss_n = ~m_on;
        pin_o.ss_n_oe = master;
        pin_o.mosi = lsbf ? sh_reg[0] : sh_reg[7];
        pin_o.mosi_oe = master;
        pin_o.miso = lsbf ? sh_reg[0] : sh_reg[7];
        pin_o.miso_oe = ~master;
    end

endmodule

`default_nettype wire

// ===== rtl/spisf_params.svh
// spisf_params.svh: offsets, field positions, reset values and timing
// counts of the spi status-flag port.
// assumes a 20 MHz core clock and a 32-bit classic wishbone bus.
`ifndef SPISF_PARAMS_SVH
`define SPISF_PARAMS_SVH

// ***************************************
// register byte offsets
// ***************************************
`define SPISF_ADR_STAT 8'h00
`define SPISF_ADR_RXBUF 8'h04
`define SPISF_ADR_TXBUF 8'h08
`define SPISF_ADR_CTRL 8'h0C
`define SPISF_ADR_EVT 8'h10
`define SPISF_ADR_MASK 8'h14

// ***************************************
// status flag bits
// ***************************************
`define SPISF_B_BUSY 7
`define SPISF_B_RXOF 5
`define SPISF_B_RXIRQ 4
`define SPISF_B_RXBF 3
`define SPISF_B_TXUF 2
`define SPISF_B_TXIRQ 1
`define SPISF_B_TXBF 0

// ***************************************
// control bits and reset
// ***************************************
`define SPISF_C_TRANSFER_IRQ_MODE 0
`define SPISF_C_OVWR 1
`define SPISF_C_MASTER 2
`define SPISF_C_LSBF 3
`define SPISF_CTRL_RST 8'h01

// ***************************************
// event bits (status and mask share layout)
// ***************************************
`define SPISF_E_TXEMPTY 0
`define SPISF_E_RXNEW 1
`define SPISF_E_RXOF 2
`define SPISF_E_TXUF 3
`define SPISF_EVT_W 4

// ***************************************
// timing
// ***************************************
`define SPISF_BYTE_BITS 8
`define SPISF_CLK_NS 50
`define SPISF_LINK_NS 400
`define SPISF_HALF_CYC (((`SPISF_LINK_NS / 2) + `SPISF_CLK_NS - 1) / `SPISF_CLK_NS)

`endif

// ===== rtl/spisf_pkg.sv
// spisf_pkg.sv: types of the spi status-flag port.
// assumes spisf_params.svh is on the include path.
package spisf_pkg;

    // master engine states
    typedef enum logic [1:0] {
        SPISF_IDLE,
        SPISF_RUN,
        SPISF_DRAIN
    } spisf_state_t;

    // pins as seen from outside
    typedef struct packed {
        logic sclk;
        logic ss_n;
        logic mosi;
        logic miso;
    } spisf_pin_in_t;

    // pin drives, each with its enable
    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic ss_n;
        logic ss_n_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
    } spisf_pin_out_t;

endpackage

// ===== rtl/spisf_sync.sv
// spisf_sync.sv: two-flop synchroniser for pin inputs.
// assumes inputs are asynchronous to clk_i; first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none

module spisf_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule

`default_nettype wire

// ===== sim/spisf_chk_sva.sv
// spisf_chk_sva.sv: port-level checks of the spi status-flag port.
// assumes it is bound into spisf_top and that ce_i is held high.
`timescale 1ns/1ns
`include "spisf_params.svh"
`default_nettype none

module spisf_chk
    import spisf_pkg::*;
#(
    parameter int HALF_CYC = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and interrupt
    input wire spisf_pin_out_t pin_o,
    input wire logic irq_o
);
    // ***************************************
    // helper counters
    // ***************************************
    logic sclk_q;
    logic [7:0] rise_cnt;
    logic [7:0] hi_cnt;
    wire logic stat_rd = wb_ack_o && !wb_we_i && wb_adr_i == `SPISF_ADR_STAT;
    wire logic rise_w = pin_o.sclk && !sclk_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            rise_cnt <= 8'h00;
            hi_cnt <= 8'h00;
        end else begin
            sclk_q <= pin_o.sclk;
            hi_cnt <= pin_o.sclk ? hi_cnt + 8'h01 : 8'h00;
            rise_cnt <= pin_o.ss_n ? 8'h00 : rise_cnt + {7'h00, rise_w};
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ***************************************
    // assertions
    // ***************************************
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_dir_split: assert property (pin_o.miso_oe != pin_o.mosi_oe)
        else $error("data line directions not opposite");
    a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && pin_o.ss_n && pin_o.miso_oe)
        else $error("outputs not quiet after reset");
    a_stat_clean: assert property (stat_rd |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[6])
        else $error("status unused bits set");
    a_tx_excl: assert property (stat_rd |-> !(wb_dat_o[1] && wb_dat_o[0]))
        else $error("tx empty and tx full together");
    a_rx_order: assert property (stat_rd && (wb_dat_o[5] || wb_dat_o[4]) |-> wb_dat_o[3])
        else $error("rx flag without rx full");
    a_byte_frame: assert property ($rose(pin_o.ss_n) && pin_o.ss_n_oe |->
        rise_cnt != 8'h00 && rise_cnt[2:0] == 3'h0)
        else $error("frame not whole bytes");
    a_sclk_half: assert property ($fell(pin_o.sclk) && pin_o.sclk_oe |-> hi_cnt == HALF_CYC)
        else $error("sclk high time wrong");
    a_ss_first: assert property ($fell(pin_o.ss_n) |-> !pin_o.sclk)
        else $error("sclk high at select");
endmodule

bind spisf_top spisf_chk #(.HALF_CYC(HALF_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_o(pin_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== sim/spisf_peer.sv
// spisf_peer.sv: external spi slave, mode 0, msb first.
// assumes sclk and ss_n from the port; byte n of a frame is tx_byte_i + n.
`timescale 1ns/1ns
`default_nettype none

module spisf_peer (
    // link pins
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    // data
    input wire logic [7:0] tx_byte_i,
    output logic miso_o,
    output logic [7:0] rx_last_o,
    output logic [7:0] rx_prev_o
);
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    logic [7:0] idx;
    logic mosi_q;
    int bits;

    initial begin
        miso_o = 1'b0;
        rx_last_o = 8'h00;
        rx_prev_o = 8'h00;
    end
    // mosi settles after select or falling edge; avoids racing the rise
    always @(negedge ss_n_i or negedge sclk_i) begin
        #1 mosi_q = mosi_i;
    end
    always @(negedge ss_n_i) begin
        idx = 8'h00;
        bits = 0;
        sh_out = tx_byte_i;
        miso_o = sh_out[7];
    end
    always @(posedge sclk_i) begin
        if (!ss_n_i) begin
            sh_in = {sh_in[6:0], mosi_q};
            bits++;
            if (bits == 8) begin
                rx_prev_o = rx_last_o;
                rx_last_o = sh_in;
                bits = 0;
                idx++;
            end
        end
    end
    always @(negedge sclk_i) begin
        if (!ss_n_i) begin
            sh_out = (bits == 0) ? tx_byte_i + idx : {sh_out[6:0], 1'b0};
            miso_o = sh_out[7];
        end
    end
    // no pull on a released line: never show the last bit
    always @(posedge ss_n_i) begin
        miso_o = ~miso_o;
    end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// testbench.sv: self-checking bench of the spi status-flag port.
// assumes spisf_peer as far side and the checker bound into the dut.
`timescale 1ns/1ns
`include "spisf_params.svh"
`default_nettype none

module testbench
    import spisf_pkg::*;
;
    logic clk_i, rst_i, wb_req, wb_we, wb_ack, tb_mosi, peer_miso, irq;
    logic [7:0] wb_adr, peer_byte, peer_rx, peer_prev, b1, b2;
    logic [31:0] wb_dat, wb_rd, wb_q;
    spisf_pin_in_t pins;
    spisf_pin_out_t pin_o;
    int err_total = 0;
    int check_count = 0;
    int seed = 89932;
    wire logic sclk_w = pin_o.sclk_oe ? pin_o.sclk : 1'b0;
    wire logic ss_w = pin_o.ss_n_oe ? pin_o.ss_n : 1'b1;
    wire logic mosi_w = pin_o.mosi_oe ? pin_o.mosi : tb_mosi;
    wire logic miso_w = pin_o.miso_oe ? pin_o.miso : peer_miso;
    assign pins = {sclk_w, ss_w, mosi_w, miso_w};

    spisf_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .pin_i(pins), .pin_o(pin_o), .irq_o(irq)
    );
    spisf_peer peer (
        .sclk_i(sclk_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .tx_byte_i(peer_byte),
        .miso_o(peer_miso), .rx_last_o(peer_rx), .rx_prev_o(peer_prev)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ***************************************
    // tasks
    // ***************************************
    task automatic end_of_test;
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_req <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            end_of_test();
        end
        wb_q = wb_rd;
        wb_req <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        wb_io(1'b1, adr, d);
    endtask
    task automatic rdc(input string name, input logic [7:0] adr, input logic [31:0] exp);
        wb_io(1'b0, adr, 32'h0);
        check(name, wb_q, exp);
    endtask
    task automatic wait_ss(input logic v);
        int n;
        n = 0;
        while (ss_w !== v && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            end_of_test();
        end
    endtask
    // buffer keeps the older byte unless overwrite is on
    function automatic logic [31:0] rx_expect(input logic ovw, input logic [7:0] p);
        return {24'h0, ovw ? p + 8'h01 : p};
    endfunction
    // lsb-first port against an msb-first peer sees the byte mirrored
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7 - i];
        end
    endfunction

    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        rst_i = 1'b1;
        wb_req = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_dat = 32'h0;
        tb_mosi = 1'b0;
        peer_byte = 8'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("status", `SPISF_ADR_STAT, 32'h00);
        rdc("ctrl", `SPISF_ADR_CTRL, 32'h01);
        rdc("unmapped", 8'h1C, 32'h00);
        wr(`SPISF_ADR_MASK, 32'h0F);
        wr(`SPISF_ADR_CTRL, 32'h05);
        check("oe", {pin_o.mosi_oe, pin_o.miso_oe}, 32'h2);
        b1 = 8'($random(seed));
        peer_byte <= 8'($random(seed));
        wr(`SPISF_ADR_TXBUF, {24'h0, b1});
        wait_ss(1'b0);
        wait_ss(1'b1);
        check("peer_rx", peer_rx, b1);
        rdc("status", `SPISF_ADR_STAT, 32'h1E);
        rdc("events", `SPISF_ADR_EVT, 32'h0B);
        check("irq", irq, 1'b1);
        rdc("rxbuf", `SPISF_ADR_RXBUF, {24'h0, peer_byte});
        rdc("status", `SPISF_ADR_STAT, 32'h06);
        wr(`SPISF_ADR_STAT, 32'hFF);
        rdc("status", `SPISF_ADR_STAT, 32'h06);
        wr(`SPISF_ADR_STAT, 32'h00);
        rdc("status", `SPISF_ADR_STAT, 32'h00);
        wr(`SPISF_ADR_MASK, 32'h00);
        check("irq", irq, 1'b0);
        wr(`SPISF_ADR_MASK, 32'h0F);
        check("irq", irq, 1'b1);
        wr(`SPISF_ADR_EVT, 32'h0F);
        check("irq", irq, 1'b0);
        rdc("events", `SPISF_ADR_EVT, 32'h00);
        for (int ovw = 0; ovw < 2; ovw++) begin
            wr(`SPISF_ADR_CTRL, 32'h05 | (ovw << 1));
            wb_io(1'b0, `SPISF_ADR_RXBUF, 32'h0);
            wr(`SPISF_ADR_STAT, 32'h00);
            b1 = 8'($random(seed));
            b2 = 8'($random(seed));
            peer_byte <= 8'($random(seed));
            wr(`SPISF_ADR_TXBUF, {24'h0, b1});
            wait_ss(1'b0);
            wr(`SPISF_ADR_TXBUF, {24'h0, b2});
            rdc("status", `SPISF_ADR_STAT, 32'h81);
            wait_ss(1'b1);
            check("peer_prev", peer_prev, b1);
            check("peer_rx", peer_rx, b2);
            rdc("status", `SPISF_ADR_STAT, 32'h3E);
            rdc("rxbuf", `SPISF_ADR_RXBUF, rx_expect(ovw[0], peer_byte));
        end
        wr(`SPISF_ADR_CTRL, 32'h0D);
        b1 = 8'($random(seed));
        peer_byte <= 8'($random(seed));
        wr(`SPISF_ADR_TXBUF, {24'h0, b1});
        wait_ss(1'b0);
        wait_ss(1'b1);
        check("peer_rx_lsb", peer_rx, rev8(b1));
        rdc("rxbuf_lsb", `SPISF_ADR_RXBUF, {24'h0, rev8(peer_byte)});
        wr(`SPISF_ADR_CTRL, 32'h01);
        tb_mosi <= 1'($random(seed));
        check("oe", {pin_o.mosi_oe, pin_o.miso_oe}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
